/* design/sub_adder_consts.svh */
// Constants for the subtractive one's-complement adder.
`ifndef SUB_ADDER_CONSTS_SVH
`define SUB_ADDER_CONSTS_SVH
`define ACC_WIDTH   24
`define GROUP_BITS  3
`define NUM_GROUPS  8
`define SIGN_BIT    23
`define ACC_RESET   24'h00_0000
`endif

/* design/sub_adder_pkg.sv */
// Types for the subtractive one's-complement adder.
`default_nettype none
package sub_adder_pkg;
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_LOAD   = 3'b001,
      ST_TOGGLE = 3'b010,
      ST_BORROW = 3'b011,
      ST_PROBE  = 3'b100,
      ST_DONE   = 3'b101
   } step_t;
endpackage
`default_nettype wire

/* design/borrow_net.sv */
// Combinational borrow network: bit borrows, group borrows, end-around borrow.
`default_nettype none
`include "sub_adder_consts.svh"
module borrow_net #(
   parameter int W = `ACC_WIDTH,
   parameter int G = `GROUP_BITS
) (
   // Toggled accumulator and operand buffer
   input  wire logic [W-1:0] acc,
   input  wire logic [W-1:0] buf_op,
   // Borrow marks for the probe step
   output logic      [W-1:0] marks
);
   // The half-register level is only a speed-up: a flat chain of group enables
   // reaches the same groups, so the halves are not built separately.
   localparam int NG = W / G;

   // Borrow walk through one group: a pending borrow marks a bit and keeps
   // climbing past zeros; bit G of the result is the borrow leaving the top.
   function automatic logic [G:0] group_walk(input logic [G-1:0] a,
                                             input logic [G-1:0] s,
                                             input logic         cin);
      logic [G:0] r;
      logic       pend;
      pend = cin;
      r    = '0;
      for (int b = 0; b < G; b++) begin
         r[b] = pend;
         pend = (pend & ~a[b]) | s[b];
      end
      r[G] = pend;
      return r;
   endfunction

   logic [W-1:0]  src;
   logic [W-1:0]  mk;
   logic [NG-1:0] gen;
   logic [NG-1:0] en;
   logic [NG-1:0] bin;
   logic [G:0]    walk;
   logic          run;
   always_comb begin
      src  = acc & buf_op;
      mk   = '0;
      walk = '0;
      run  = 1'b0;
      for (int g = 0; g < NG; g++) begin
         en[g]  = ~|acc[g*G +: G];
         walk   = group_walk(acc[g*G +: G], src[g*G +: G], 1'b0);
         gen[g] = walk[G];
      end
      for (int g = 0; g < NG; g++) begin
         bin[g] = 1'b0;
         run    = 1'b1;
         // Look down through enabled groups; below group 0 the top group follows.
         for (int d = 1; d <= NG; d++) begin
            if (run && gen[(g + NG - d) % NG]) begin
               bin[g] = 1'b1;
            end
            run = run & en[(g + NG - d) % NG];
         end
         walk         = group_walk(acc[g*G +: G], src[g*G +: G], bin[g]);
         mk[g*G +: G] = walk[G-1:0];
      end
   end
   assign marks = mk;
endmodule
`default_nettype wire

/* design/sub_ones_adder.sv */
// Top of the subtractive one's-complement adder with its step sequencer.
// Overview of operation
// - Buffer bit 0 leaves the accumulator bit unchanged.
// - Buffer bit 1 inverts accumulator bit; a 0-to-1 change requests a borrow.
// - Add loads complemented operand into buffer; operand register stays intact.
// - Toggle step inverts all accumulator bits where buffer is 1, in parallel.
// - Accumulator and buffer both 1 marks higher bit, continuing through zeros.
// - Group borrow when a bit borrow has only zeros above it in its group.
// - Group borrow propagates fast, marking bits up to lowest bit holding 1.
// - All-zero group passes a borrow through and marks all its bits.
// - Borrow leaving the top group wraps into the lowest accumulator bit.
// - Probe inverts every accumulator bit carrying any borrow mark.
// - Steps run load, toggle, bit and group borrows in one step, then probe.
// - Subtract runs the same steps with the operand loaded uncomplemented.
// - Top accumulator bit is the sign: 1 negative, 0 positive.
// - Accumulator is 24 bits; borrows resolve within one clock cycle.
// - Borrow generation uses eight three-bit groups in one flat chain.
// - Add and subtract yield all ones only from an all-ones accumulator with a zero buffer.
`default_nettype none
`include "sub_adder_consts.svh"
module sub_ones_adder
   import sub_adder_pkg::*;
#(
   parameter int W = `ACC_WIDTH
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         arst_n,
   // Step requests from the sequencer
   input  wire logic         op_start,
   input  wire logic         op_sub,
   input  wire logic [W-1:0] operand,
   input  wire logic         acc_load,
   input  wire logic [W-1:0] acc_in,
   // Results
   output logic      [W-1:0] acc_q,
   output logic      [W-1:0] operand_complement_buffer_q,
   output logic              busy_q,
   output logic              done_q,
   output logic              sign_q
);
   ////////////////////////////////////////////////////////////////////////////
   step_t        step_q;
   logic [W-1:0] marks;
   logic [W-1:0] marks_q;
   logic [W-1:0] operand_q;

   borrow_net #(.W(W), .G(`GROUP_BITS)) u_net (
      .acc    (acc_q),
      .buf_op (operand_complement_buffer_q),
      .marks  (marks)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer. The operand is sampled at start, but op_sub is read at the load step,
   // so a careless sequencer can still corrupt the buffer load by moving op_sub early.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         step_q <= ST_IDLE;
      end else begin
         case (step_q)
            ST_IDLE:   step_q <= op_start ? ST_LOAD : ST_IDLE;
            ST_LOAD:   step_q <= ST_TOGGLE;
            ST_TOGGLE: step_q <= ST_BORROW;
            ST_BORROW: step_q <= ST_PROBE;
            ST_PROBE:  step_q <= ST_DONE;
            ST_DONE:   step_q <= ST_IDLE;
            default:   step_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         operand_q <= '0;
      end else if (step_q == ST_IDLE && op_start) begin
         operand_q <= operand;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         operand_complement_buffer_q <= '0;
      end else if (step_q == ST_LOAD) begin
         operand_complement_buffer_q <= op_sub ? operand_q : ~operand_q;
      end
   end

   // Bit and group borrows settle together in one cycle off the toggled value.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         marks_q <= '0;
      end else if (step_q == ST_BORROW) begin
         marks_q <= marks;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         acc_q <= `ACC_RESET;
      end else if (step_q == ST_TOGGLE) begin
         acc_q <= acc_q ^ operand_complement_buffer_q;
      end else if (step_q == ST_PROBE) begin
         acc_q <= acc_q ^ marks_q;
      end else if (step_q == ST_IDLE && acc_load) begin
         acc_q <= acc_in;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
         sign_q <= 1'b0;
      end else begin
         busy_q <= (step_q != ST_IDLE && step_q != ST_DONE) || (step_q == ST_IDLE && op_start);
         done_q <= (step_q == ST_PROBE);
         sign_q <= (step_q == ST_PROBE) ? acc_q[`SIGN_BIT] ^ marks_q[`SIGN_BIT]
                 : (step_q == ST_TOGGLE)
                 ? acc_q[`SIGN_BIT] ^ operand_complement_buffer_q[`SIGN_BIT]
                 : (step_q == ST_IDLE && acc_load) ? acc_in[`SIGN_BIT]
                 : acc_q[`SIGN_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   property p_order;
      @(posedge clk) disable iff (!arst_n)
      (step_q == ST_IDLE && op_start) |=> step_q == ST_LOAD ##1 step_q == ST_TOGGLE
         ##1 step_q == ST_BORROW ##1 step_q == ST_PROBE ##1 step_q == ST_DONE;
   endproperty
   a_order: assert property (p_order) else $error("step order broken");

   property p_load;
      @(posedge clk) disable iff (!arst_n)
      (step_q == ST_LOAD) |=>
         operand_complement_buffer_q == ($past(op_sub) ? operand_q : ~operand_q);
   endproperty
   a_load: assert property (p_load) else $error("buffer load wrong");

   property p_toggle;
      @(posedge clk) disable iff (!arst_n)
      (step_q == ST_TOGGLE) |=> acc_q == ($past(acc_q) ^ operand_complement_buffer_q);
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle wrong");

   property p_probe;
      @(posedge clk) disable iff (!arst_n)
      (step_q == ST_PROBE) |=> acc_q == ($past(acc_q) ^ marks_q) && done_q;
   endproperty
   a_probe: assert property (p_probe) else $error("probe wrong");

   property p_sign;
      @(posedge clk) disable iff (!arst_n)
      ##1 sign_q == acc_q[`SIGN_BIT];
   endproperty
   a_sign: assert property (p_sign) else $error("sign mismatch");

   property p_sum;
      @(posedge clk) disable iff (!arst_n)
      (step_q == ST_IDLE && op_start && !acc_load) ##1 1'b1 [*4] ##1 1'b1 |->
         acc_q == W'(({1'b0, $past(acc_q, 5)} + {1'b0, $past(op_sub, 4) ? ~operand_q
            : operand_q}) + (({1'b0, $past(acc_q, 5)} + {1'b0, $past(op_sub, 4) ?
            ~operand_q : operand_q}) >> W)) || acc_q == '0 || acc_q == '1;
   endproperty
   a_sum: assert property (p_sum) else $error("sum wrong");

   property p_quiet;
      @(posedge clk) disable iff (!arst_n)
      (step_q == ST_IDLE && !op_start && !acc_load) |=> $stable(acc_q);
   endproperty
   a_quiet: assert property (p_quiet) else $error("acc changed when idle");

   property p_busy;
      @(posedge clk) disable iff (!arst_n)
      (step_q == ST_IDLE && op_start) |=> busy_q [*4] ##1 (busy_q && done_q)
         ##1 (!busy_q && !done_q);
   endproperty
   a_busy: assert property (p_busy) else $error("busy/done timing");

   // The latched operand stands for the whole operation.
   property p_operand_hold;
      @(posedge clk) disable iff (!arst_n)
      (step_q != ST_IDLE) |=> $stable(operand_q);
   endproperty
   a_operand_hold: assert property (p_operand_hold) else $error("operand moved");

   property p_buf_hold;
      @(posedge clk) disable iff (!arst_n)
      (step_q != ST_LOAD) |=> $stable(operand_complement_buffer_q);
   endproperty
   a_buf_hold: assert property (p_buf_hold) else $error("buffer moved");

   property p_refuse;
      @(posedge clk) disable iff (!arst_n)
      (step_q != ST_IDLE) |=> step_q != ST_LOAD;
   endproperty
   a_refuse: assert property (p_refuse) else $error("start taken while busy");

   property p_done_pulse;
      @(posedge clk) disable iff (!arst_n)
      done_q |=> !done_q;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done too long");

   property p_done_state;
      @(posedge clk) disable iff (!arst_n)
      done_q |-> step_q == ST_DONE;
   endproperty
   a_done_state: assert property (p_done_state) else $error("done out of step");

   property p_no_neg_zero;
      @(posedge clk) disable iff (!arst_n)
      (step_q == ST_PROBE) |=> acc_q != '1
         || ($past(acc_q, 3) == '1 && operand_complement_buffer_q == '0);
   endproperty
   a_no_neg_zero: assert property (p_no_neg_zero) else $error("negative zero made");

   property p_zero_buf;
      @(posedge clk) disable iff (!arst_n)
      (step_q == ST_PROBE && operand_complement_buffer_q == '0) |=> acc_q == $past(acc_q, 3);
   endproperty
   a_zero_buf: assert property (p_zero_buf) else $error("zero operand changed acc");

   property p_marks_hold;
      @(posedge clk) disable iff (!arst_n)
      (step_q != ST_BORROW) |=> $stable(marks_q);
   endproperty
   a_marks_hold: assert property (p_marks_hold) else $error("marks moved");
endmodule
`default_nettype wire

/* dv/seq_model.sv */
// Behavioural model of the sequencer that issues add and subtract steps.
`default_nettype none
module seq_model (
   // Clock
   input  wire logic        clk,
   // Requests to the adder
   output var  logic        op_start,
   output var  logic        op_sub,
   output var  logic [23:0] operand,
   // Completion from the adder
   input  wire logic        done_q
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      op_start = 1'b0;
      op_sub   = 1'b0;
      operand  = 24'h00_0000;
   end
   // Lat counts edges from the drive; the take edge is the first of them.
   task automatic issue(input logic sub, input logic [23:0] x, output int lat);
      lat = 0;
      @(posedge clk);
      #1;
      op_start = 1'b1;
      op_sub   = sub;
      operand  = x;
      while (lat < 12 && done_q !== 1'b1) begin
         @(posedge clk);
         #1;
         lat++;
      end
      // Released lines flip so that a stale value cannot pass unnoticed.
      op_start = 1'b0;
      op_sub   = ~sub;
      operand  = ~x;
   endtask
endmodule
`default_nettype wire

/* dv/sub_ones_adder_test.sv */
// Self-checking bench for the subtractive one's-complement adder.
`default_nettype none
module sub_ones_adder_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk;
   logic        arst_n;
   logic        op_start;
   logic        op_sub;
   logic        acc_load;
   logic [23:0] operand;
   logic [23:0] acc_in;
   logic [23:0] acc_q;
   logic [23:0] buf_q;
   logic        busy_q;
   logic        done_q;
   logic        sign_q;
   int          bad_count;
   int          n_tests;
   sub_ones_adder uut (.clk(clk), .arst_n(arst_n), .op_start(op_start), .op_sub(op_sub),
      .operand(operand), .acc_load(acc_load), .acc_in(acc_in), .acc_q(acc_q),
      .operand_complement_buffer_q(buf_q), .busy_q(busy_q), .done_q(done_q), .sign_q(sign_q));
   seq_model seq (.clk(clk), .op_start(op_start), .op_sub(op_sub), .operand(operand),
      .done_q(done_q));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [23:0] ref_sub(input logic [23:0] a, input logic [23:0] b);
      logic [24:0] d;
      d = {1'b0, a} - {1'b0, b};
      return d[23:0] - 24'(d[24]);
   endfunction
   task automatic cmp_val(input logic [23:0] got, input logic [23:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_lat(input int got, input int exp);
      n_tests++;
      if (got != exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks=%0d mismatches=%0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Presets the accumulator, then lets the sequencer model run one operation.
   task automatic run_op(input logic [23:0] a, input logic [23:0] x, input logic sub);
      int          lat;
      logic [23:0] exp;
      @(posedge clk);
      #1;
      acc_load = 1'b1;
      acc_in   = a;
      @(posedge clk);
      #1;
      acc_load = 1'b0;
      acc_in   = ~a;
      cmp_val(acc_q, a);
      exp = ref_sub(a, sub ? x : ~x);
      seq.issue(sub, x, lat);
      cmp_lat(lat, 5);
      if (lat > 11) begin
         complete_run();
      end
      cmp_val(acc_q, exp);
      cmp_val(buf_q, sub ? x : ~x);
      cmp_val({21'h00_0000, busy_q, sign_q, done_q}, {21'h00_0000, 1'b1, exp[23], 1'b1});
      @(posedge clk);
      #1;
      cmp_val({22'h00_0000, busy_q, done_q}, 24'h00_0000);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      cmp_val(acc_q | buf_q | {21'h00_0000, busy_q, done_q, sign_q}, 24'h00_0000);
      $display("test reset done");
   endtask
   task automatic t_doc_ops();
      run_op(24'h00_04AD, 24'h00_0344, 1'b0);
      run_op(24'h00_07F1, 24'h00_034C, 1'b1);
      $display("test doc_ops done");
   endtask
   task automatic t_end_around();
      run_op(24'h00_0001, 24'h00_0002, 1'b1);
      run_op(24'h00_0005, 24'h00_0006, 1'b1);
      $display("test end_around done");
   endtask
   task automatic t_long_borrow();
      run_op(24'h80_0000, 24'h00_0001, 1'b1);
      $display("test long_borrow done");
   endtask
   task automatic t_zero_operand();
      run_op(24'hA5_A5A5, 24'h00_0000, 1'b0);
      run_op(24'h5A_5A5A, 24'h00_0000, 1'b1);
      $display("test zero_operand done");
   endtask
   task automatic t_no_neg_zero();
      run_op(24'h00_0005, 24'hFF_FFFA, 1'b0);
      run_op(24'h12_3456, 24'h12_3456, 1'b1);
      $display("test no_neg_zero done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      arst_n    = 1'b0;
      acc_load  = 1'b0;
      acc_in    = 24'h00_0000;
      bad_count = 0;
      n_tests   = 0;
      repeat (6) @(posedge clk);
      #1;
      arst_n = 1'b1;
      t_reset();
      t_doc_ops();
      t_end_around();
      t_long_borrow();
      t_zero_operand();
      t_no_neg_zero();
      complete_run();
   end
endmodule
`default_nettype wire
